/* File: include/tss_defs.svh */
`ifndef TSS_DEFS_SVH
`define TSS_DEFS_SVH

// core clock
`define TSS_CLK_HZ        250000000
`define TSS_CLK_MHZ       250

// shortest duration step in microseconds, longer codes double it
`define TSS_DUR_BASE_US   15625
`define TSS_DUR_BASE_CYC  (`TSS_DUR_BASE_US * `TSS_CLK_MHZ)

// debounce settle time in microseconds
`define TSS_DEBOUNCE_US   9000
`define TSS_DEBOUNCE_CYC  (`TSS_DEBOUNCE_US * `TSS_CLK_MHZ)

// tone frequencies in millihertz, codes 0010 to 1111
`define TSS_F_C5_MHZ      523250
`define TSS_F_D5_MHZ      587330
`define TSS_F_E5_MHZ      659260
`define TSS_F_F5_MHZ      698460
`define TSS_F_G5_MHZ      783990
`define TSS_F_A5_MHZ      880000
`define TSS_F_B5_MHZ      987770
`define TSS_F_C6_MHZ      1046500
`define TSS_F_E6_MHZ      1318500
`define TSS_F_G6_MHZ      1568000
`define TSS_F_A6_MHZ      1760000
`define TSS_F_C7_MHZ      2093000
`define TSS_F_D7_MHZ      2349300
`define TSS_F_E7_MHZ      2637000

// tone_command layout and special values
`define TSS_DUR_MSB       7
`define TSS_DUR_LSB       5
`define TSS_TONE_MSB      4
`define TSS_TONE_LSB      1
`define TSS_QUEUE_BIT     0
`define TSS_CMD_RESET     8'h00
`define TSS_CMD_LOOP      8'h01
`define TSS_CMD_HALT      8'h03
`define TSS_DUR_CONT      3'h0
`define TSS_DUR_MAX       3'h7
`define TSS_CFG_RUN_BIT   7

`endif

/* File: include/tss_pkg.sv */
package tss_pkg;

  typedef enum logic [1:0] {
    PL_IDLE = 2'b00,
    PL_PLAY = 2'b01,
    PL_TAIL = 2'b10
  } tss_play_t;

  typedef logic [7:0] tss_cmd_t;

endpackage

/* File: logic/tss_sounder.sv */
`include "tss_defs.svh"
`timescale 1ns/100ps
module tss_sounder import tss_pkg::*; #(
  parameter int unsigned DUR_BASE_CYC = `TSS_DUR_BASE_CYC,
  parameter int unsigned DEBOUNCE_CYC = `TSS_DEBOUNCE_CYC,
  parameter int unsigned TONE_SHIFT   = 0
) (
  input  wire logic        clk,                       // core clock
  input  wire logic        sys_rst,                   // sync reset
  input  wire logic        snd_wr,                    // tone_command write
  input  wire tss_cmd_t    snd_wr_data,               // write data
  output tss_cmd_t         snd_rd_data_ff,            // tone_command read
  output logic             snd_wr_ack_ff,             // write taken
  output logic             snd_wr_nack_ff,            // write refused
  input  wire logic        cfg_wr,                    // config write
  input  wire logic [7:0]  cfg_wr_data,               // config data
  output logic             run_mode_ff,               // operating mode
  input  wire logic        alert_evt,                 // alert sound event
  input  wire tss_cmd_t    alert_cmd,                 // alert sound command
  input  wire logic        key_evt,                   // key click event
  input  wire tss_cmd_t    key_cmd,                   // key click command
  output logic             sounder_out_ff,            // sounder pin
  input  wire logic        alert_in,                  // alert input level
  input  wire logic        alert_irq_en,              // alert irq enable
  input  wire logic        alert_irq_clr,             // clear pending alert
  output logic             alert_status_ff,           // alert status
  input  wire logic        int_gpo_en,                // irq pin as output
  input  wire logic        int_gpo_val,               // irq pin level
  output logic             irq_oe_ff,                 // drives irq pin low
  input  wire logic [63:0] key_sense,                 // current draw, row*8+col
  output logic [63:0]      key_state_ff,              // debounced keys
  output logic             key_fifo_clr_ff,           // key queue clear pulse
  input  wire logic [5:0]  shared_column_output_en,   // cols 2-7 as outputs
  input  wire logic [5:0]  shared_column_output_val,  // their levels
  output logic [7:0]       matrix_row_line_o_ff,      // row drive value
  output logic [7:0]       matrix_row_line_oe_ff,     // row enable
  output logic [7:0]       matrix_column_line_o_ff,   // column drive value
  output logic [7:0]       matrix_column_line_oe_ff   // column enable
);

  tss_cmd_t    act_ff, q_ff, ld_cmd;
  logic        act_vld_ff, act_alert_ff, q_vld_ff, q_alert_ff;
  logic        loop_ff, halt_ff, phase2_ff;
  tss_play_t   state_ff;
  logic [31:0] dur_ff;
  logic [19:0] half_ff;
  logic        tone_ff, cont_ff;
  logic        evt, exit_sd, enter_sd, alert_busy, wr_take, end_now;
  tss_cmd_t    evt_cmd;
  logic        ld_en, ld_alert, stop_en, stop_keep;
  logic [63:0] key_filt, key_smp_ff;
  logic [31:0] deb_ff;
  logic        alert_pend_ff;

  // duration in cycles; zero means continuous
  function automatic logic [31:0] dur_cycles(input logic [2:0] code,
                                             input logic alert);
    logic [2:0] ce;
    ce = (code == `TSS_DUR_CONT && alert) ? `TSS_DUR_MAX : code;
    if (ce == `TSS_DUR_CONT)
      return 32'h0;
    return DUR_BASE_CYC << (ce - 3'h1);
  endfunction

  // half period of a tone in cycles
  function automatic logic [19:0] tone_half(input logic [3:0] code);
    longint unsigned f, h;
    case (code)
      4'h2:    f = `TSS_F_C5_MHZ;
      4'h3:    f = `TSS_F_D5_MHZ;
      4'h4:    f = `TSS_F_E5_MHZ;
      4'h5:    f = `TSS_F_F5_MHZ;
      4'h6:    f = `TSS_F_G5_MHZ;
      4'h7:    f = `TSS_F_A5_MHZ;
      4'h8:    f = `TSS_F_B5_MHZ;
      4'h9:    f = `TSS_F_C6_MHZ;
      4'ha:    f = `TSS_F_E6_MHZ;
      4'hb:    f = `TSS_F_G6_MHZ;
      4'hc:    f = `TSS_F_A6_MHZ;
      4'hd:    f = `TSS_F_C7_MHZ;
      4'he:    f = `TSS_F_D7_MHZ;
      default: f = `TSS_F_E7_MHZ;
    endcase
    h = ((64'(`TSS_CLK_HZ) * 64'd500) / f) >> TONE_SHIFT;
    return (h == 64'h0) ? 20'h1 : h[19:0];
  endfunction

  // drop every pressed key on a rectangle with three pressed corners
  function automatic logic [63:0] ghost_filter(input logic [63:0] k);
    logic [63:0] res;
    res = k;
    for (int r = 0; r < 8; r++) begin
      for (int c = 0; c < 8; c++) begin
        for (int r2 = 0; r2 < 8; r2++) begin
          for (int c2 = 0; c2 < 8; c2++) begin
            if (r2 != r && c2 != c &&
                (int'(k[r*8+c]) + int'(k[r*8+c2]) + int'(k[r2*8+c]) +
                 int'(k[r2*8+c2])) >= 3) begin
              res[r*8+c] = 1'b0;
            end
          end
        end
      end
    end
    return res;
  endfunction

  assign evt        = alert_evt | key_evt;
  assign evt_cmd    = alert_evt ? alert_cmd : key_cmd;
  assign exit_sd    = cfg_wr & cfg_wr_data[`TSS_CFG_RUN_BIT] & ~run_mode_ff;
  assign enter_sd   = cfg_wr & ~cfg_wr_data[`TSS_CFG_RUN_BIT] & run_mode_ff;
  assign alert_busy = (act_vld_ff & act_alert_ff) | (q_vld_ff & q_alert_ff);
  assign wr_take    = snd_wr & run_mode_ff & ~alert_busy & ~cfg_wr;
  // a tone may end only as its low half runs out
  assign end_now = (state_ff == PL_TAIL ||
                    (state_ff == PL_PLAY && !cont_ff && dur_ff == 32'h1)) &&
                   (!tone_ff || (half_ff == 20'h1 && !sounder_out_ff));

  // decide what the playback unit does this cycle
  always_comb begin
    ld_en     = 1'b0;
    ld_cmd    = snd_wr_data;
    ld_alert  = 1'b0;
    stop_en   = 1'b0;
    stop_keep = 1'b0;
    if (exit_sd || enter_sd) begin
      stop_en   = 1'b1;
      stop_keep = enter_sd;
    end else if (!run_mode_ff) begin
      stop_en = 1'b0;
    end else if (evt) begin
      if (!(act_vld_ff && act_alert_ff) || end_now) begin
        ld_en    = 1'b1;
        ld_cmd   = {evt_cmd[7:1], 1'b0};
        ld_alert = 1'b1;
      end
    end else if (wr_take) begin
      if (!snd_wr_data[`TSS_QUEUE_BIT]) begin
        if (snd_wr_data == `TSS_CMD_RESET)
          stop_en = 1'b1;
        else
          ld_en = 1'b1;
      end else if (snd_wr_data != `TSS_CMD_LOOP &&
                   snd_wr_data != `TSS_CMD_HALT && !act_vld_ff) begin
        ld_en = 1'b1;
      end
    end else if (end_now) begin
      if (q_vld_ff && !(loop_ff && halt_ff && phase2_ff)) begin
        ld_en    = 1'b1;
        ld_cmd   = q_ff;
        ld_alert = q_alert_ff;
      end else begin
        stop_en = 1'b1;
      end
    end
  end

  // command bookkeeping: active, queued and autoloop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      act_ff       <= `TSS_CMD_RESET;
      act_vld_ff   <= 1'b0;
      act_alert_ff <= 1'b0;
      q_ff         <= `TSS_CMD_RESET;
      q_vld_ff     <= 1'b0;
      q_alert_ff   <= 1'b0;
      loop_ff      <= 1'b0;
      halt_ff      <= 1'b0;
      phase2_ff    <= 1'b0;
    end else if (stop_en) begin
      act_vld_ff   <= 1'b0;
      act_alert_ff <= 1'b0;
      q_vld_ff     <= 1'b0;
      q_alert_ff   <= 1'b0;
      loop_ff      <= 1'b0;
      halt_ff      <= 1'b0;
      phase2_ff    <= 1'b0;
    end else if (ld_en) begin
      act_ff       <= ld_cmd;
      act_vld_ff   <= 1'b1;
      act_alert_ff <= ld_alert;
      if (end_now && !evt && !wr_take && loop_ff) begin
        // autoloop swaps the two commands
        q_ff      <= act_ff;
        phase2_ff <= ~phase2_ff;
      end else if (end_now && !evt && !wr_take) begin
        q_vld_ff   <= 1'b0;
        q_alert_ff <= 1'b0;
      end else begin
        q_vld_ff   <= 1'b0;
        q_alert_ff <= 1'b0;
        loop_ff    <= 1'b0;
        halt_ff    <= 1'b0;
        phase2_ff  <= 1'b0;
      end
    end else if (run_mode_ff && evt) begin
      q_ff       <= {evt_cmd[7:1], 1'b0};
      q_vld_ff   <= 1'b1;
      q_alert_ff <= 1'b1;
    end else if (wr_take && snd_wr_data == `TSS_CMD_LOOP) begin
      loop_ff   <= act_vld_ff & q_vld_ff;
      halt_ff   <= 1'b0;
      phase2_ff <= 1'b0;
    end else if (wr_take && snd_wr_data == `TSS_CMD_HALT) begin
      halt_ff <= 1'b1;
    end else if (wr_take) begin
      q_ff       <= snd_wr_data;
      q_vld_ff   <= 1'b1;
      q_alert_ff <= 1'b0;
    end
  end

  // playback: duration count, tone divider, output level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff       <= PL_IDLE;
      dur_ff         <= 32'h0;
      half_ff        <= 20'h1;
      tone_ff        <= 1'b0;
      cont_ff        <= 1'b0;
      sounder_out_ff <= 1'b0;
    end else if (stop_en) begin
      state_ff <= PL_IDLE;
      if (!stop_keep)
        sounder_out_ff <= 1'b0;
    end else if (ld_en) begin
      state_ff <= PL_PLAY;
      dur_ff   <= dur_cycles(ld_cmd[`TSS_DUR_MSB:`TSS_DUR_LSB], ld_alert);
      cont_ff  <= (dur_cycles(ld_cmd[`TSS_DUR_MSB:`TSS_DUR_LSB],
                              ld_alert) == 32'h0);
      tone_ff  <= ld_cmd[`TSS_TONE_MSB:`TSS_TONE_LSB] > 4'h1;
      half_ff  <= tone_half(ld_cmd[`TSS_TONE_MSB:`TSS_TONE_LSB]);
      // level commands hold their level, tones start high
      sounder_out_ff <= (ld_cmd[`TSS_TONE_MSB:`TSS_TONE_LSB] > 4'h1) |
                        ld_cmd[`TSS_TONE_LSB];
    end else if (state_ff != PL_IDLE && run_mode_ff) begin
      if (state_ff == PL_PLAY && !cont_ff) begin
        dur_ff <= dur_ff - 32'h1;
        if (dur_ff == 32'h1)
          state_ff <= PL_TAIL;
      end
      if (tone_ff) begin
        if (half_ff == 20'h1) begin
          half_ff        <= tone_half(act_ff[`TSS_TONE_MSB:`TSS_TONE_LSB]);
          sounder_out_ff <= ~sounder_out_ff;
        end else begin
          half_ff <= half_ff - 20'h1;
        end
      end
    end
  end

  // register answers; writes are acked unless an alert sound owns it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      snd_rd_data_ff <= `TSS_CMD_RESET;
      snd_wr_ack_ff  <= 1'b0;
      snd_wr_nack_ff <= 1'b0;
    end else begin
      snd_rd_data_ff <= act_vld_ff ? {act_ff[7:1], q_vld_ff}
                                   : `TSS_CMD_RESET;
      snd_wr_ack_ff  <= snd_wr & ~(run_mode_ff & alert_busy);
      snd_wr_nack_ff <= snd_wr & run_mode_ff & alert_busy;
    end
  end

  // run bit; powers up in shutdown until software sets it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_mode_ff     <= 1'b0;
      key_fifo_clr_ff <= 1'b0;
    end else begin
      if (cfg_wr)
        run_mode_ff <= cfg_wr_data[`TSS_CFG_RUN_BIT];
      key_fifo_clr_ff <= exit_sd;
    end
  end

  assign key_filt = ghost_filter(key_sense);

  // debounce counter only moves while a key draws current
  always_ff @(posedge clk) begin
    if (sys_rst || !run_mode_ff) begin
      key_state_ff <= 64'h0;
      key_smp_ff   <= 64'h0;
      deb_ff       <= 32'h0;
    end else if (key_filt == 64'h0) begin
      key_state_ff <= 64'h0;
      key_smp_ff   <= 64'h0;
      deb_ff       <= 32'h0;
    end else if (key_filt != key_smp_ff) begin
      key_smp_ff <= key_filt;
      deb_ff     <= 32'h0;
    end else if (deb_ff >= DEBOUNCE_CYC - 1) begin
      key_state_ff <= key_smp_ff;
    end else begin
      deb_ff <= deb_ff + 32'h1;
    end
  end

  // alert path stays alive in shutdown so it can wake the host
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alert_status_ff <= 1'b0;
      alert_pend_ff   <= 1'b0;
      irq_oe_ff       <= 1'b0;
    end else begin
      alert_status_ff <= alert_in;
      if (alert_irq_en && alert_in && !alert_status_ff)
        alert_pend_ff <= 1'b1;
      else if (alert_irq_clr)
        alert_pend_ff <= 1'b0;
      irq_oe_ff <= int_gpo_en ? ~int_gpo_val : alert_pend_ff;
    end
  end

  // open-drain matrix lines; shared columns keep following software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      matrix_row_line_o_ff     <= 8'h00;
      matrix_row_line_oe_ff    <= 8'h00;
      matrix_column_line_o_ff  <= 8'h00;
      matrix_column_line_oe_ff <= 8'h00;
    end else begin
      matrix_row_line_oe_ff <= run_mode_ff ? 8'hff : 8'h00;
      matrix_column_line_oe_ff <=
        ({2'h0, shared_column_output_en & ~shared_column_output_val} << 2) |
        (run_mode_ff ? ~({shared_column_output_en, 2'h0}) : 8'h00);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_wr_busy;
    snd_wr && run_mode_ff && alert_busy;
  endsequence
  sequence s_sleep_two;
    !run_mode_ff ##1 !run_mode_ff && !cfg_wr;
  endsequence

  a_busy_write_nack: assert property (s_wr_busy |=> snd_wr_nack_ff &&
    !snd_wr_ack_ff) else $error("write taken during alert sound");
  a_busy_read_ok: assert property (act_vld_ff && act_alert_ff |=>
    snd_rd_data_ff[0] == $past(q_vld_ff))
    else $error("read wrong during alert");
  a_event_aborts: assert property (evt && run_mode_ff && !alert_busy &&
    !cfg_wr |=> act_alert_ff && !q_vld_ff)
    else $error("alert did not abort user");
  a_event_queued: assert property (evt && run_mode_ff && act_vld_ff &&
    act_alert_ff && !end_now && !cfg_wr |=> q_vld_ff && q_alert_ff)
    else $error("alert event not queued");
  a_tone_ends_low: assert property (end_now && tone_ff && run_mode_ff
    |-> !sounder_out_ff) else $error("tone cut mid cycle");
  a_rows_float: assert property (s_sleep_two |-> matrix_row_line_oe_ff ==
    8'h00) else $error("rows driven in shutdown");
  a_sleep_hold: assert property (s_sleep_two |=> $stable(sounder_out_ff) &&
    $stable(act_vld_ff)) else $error("sounder moved in shutdown");
  a_wake_clears: assert property (exit_sd |=> key_fifo_clr_ff &&
    !q_vld_ff && !act_vld_ff) else $error("wake left queues");
  a_rerun_keeps: assert property (cfg_wr && cfg_wr_data[7] && run_mode_ff
    |=> !key_fifo_clr_ff) else $error("queues cleared on rewrite");
  a_alert_wake: assert property (alert_irq_en && alert_in &&
    !alert_status_ff && !int_gpo_en ##1 !int_gpo_en |=> irq_oe_ff)
    else $error("alert did not interrupt");
  a_debounce_idle: assert property (run_mode_ff && key_filt == 64'h0
    |=> deb_ff == 32'h0) else $error("debounce ran with no key");

endmodule

/* File: tb/tss_host_model.sv */
`timescale 1ns/100ps
module tss_host_model import tss_pkg::*; (
  input  wire logic  clk,            // core clock
  input  wire logic  snd_wr_ack_ff,  // write taken
  input  wire logic  snd_wr_nack_ff, // write refused
  output logic       snd_wr,         // tone_command strobe
  output tss_cmd_t   snd_wr_data,    // tone_command data
  output logic       cfg_wr,         // config strobe
  output logic [7:0] cfg_wr_data     // config data, bit 7 = run
);
  initial begin
    snd_wr      = 1'b0;
    snd_wr_data = 8'h00;
    cfg_wr      = 1'b0;
    cfg_wr_data = 8'h00;
  end
  // released data is inverted so a late sample cannot match by luck;
  // the answer stands for one cycle only, so it is read just after the
  // edge that took the strobe
  task automatic snd_write(input tss_cmd_t d, output logic [1:0] an);
    @(posedge clk);
    snd_wr      <= 1'b1;
    snd_wr_data <= d;
    @(posedge clk);
    snd_wr      <= 1'b0;
    snd_wr_data <= ~d;
    #1;
    an = {snd_wr_ack_ff, snd_wr_nack_ff};
  endtask
  // run bit low enters shutdown, high leaves it
  task automatic cfg_write(input logic [7:0] d);
    @(posedge clk);
    cfg_wr      <= 1'b1;
    cfg_wr_data <= d;
    @(posedge clk);
    cfg_wr      <= 1'b0;
    cfg_wr_data <= ~d;
  endtask
endmodule

/* File: tb/tss_sounder_tb.sv */
`timescale 1ns/100ps
`include "tss_defs.svh"
module tss_sounder_tb;
  import tss_pkg::*;
  localparam int BASE = 40;
  logic        clk, sys_rst, alert_evt, key_evt, alert_in, alert_irq_en;
  logic        int_gpo_en, int_gpo_val, p, irq_oe_ff, key_fifo_clr_ff;
  logic        snd_wr, cfg_wr, run_mode_ff, snd_wr_ack_ff, snd_wr_nack_ff;
  logic        sounder_out_ff, alert_status_ff;
  tss_cmd_t    snd_wr_data, snd_rd_data_ff, alert_cmd, key_cmd;
  logic [7:0]  cfg_wr_data, row_o, row_oe, col_o, col_oe;
  logic [5:0]  sco_en, sco_val;
  logic [63:0] key_sense, key_state_ff;
  logic [1:0]  an;
  int          n_mismatch, checks, n, h;
  logic [3:0]  tone_code [5] = '{4'h2, 4'hc, 4'hd, 4'he, 4'hf};
  longint      tone_mhz [5] = '{`TSS_F_C5_MHZ, `TSS_F_A6_MHZ,
                                `TSS_F_C7_MHZ, `TSS_F_D7_MHZ, `TSS_F_E7_MHZ};

  tss_sounder #(.DUR_BASE_CYC(BASE), .DEBOUNCE_CYC(8), .TONE_SHIFT(12))
    i_tss_sounder (
    .clk, .sys_rst, .snd_wr, .snd_wr_data, .snd_rd_data_ff, .snd_wr_ack_ff,
    .snd_wr_nack_ff, .cfg_wr, .cfg_wr_data, .run_mode_ff, .alert_evt,
    .alert_cmd, .key_evt, .key_cmd, .sounder_out_ff, .alert_in,
    .alert_irq_en, .alert_irq_clr(1'b0), .alert_status_ff, .int_gpo_en,
    .int_gpo_val, .irq_oe_ff, .key_sense, .key_state_ff, .key_fifo_clr_ff,
    .shared_column_output_en(sco_en), .shared_column_output_val(sco_val),
    .matrix_row_line_o_ff(row_o), .matrix_row_line_oe_ff(row_oe),
    .matrix_column_line_o_ff(col_o), .matrix_column_line_oe_ff(col_oe));

  tss_host_model i_tss_host_model (.clk, .snd_wr_ack_ff, .snd_wr_nack_ff,
    .snd_wr, .snd_wr_data, .cfg_wr, .cfg_wr_data);

  // half period in cycles, with the same shift the bench passes down
  function automatic int half(input int i);
    return int'((64'h1d_1a94_a200 / tone_mhz[i]) >> 12);
  endfunction
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input tss_cmd_t d, input logic [1:0] exp);
    i_tss_host_model.snd_write(d, an);
    check(an, exp);
  endtask
  // lvl picks the sounder pin, else waits for an empty register
  task automatic wait_on(input logic lvl, input logic v);
    n = 0;
    while (lvl ? sounder_out_ff !== v : snd_rd_data_ff !== 8'h00) begin
      tick(1);
      n++;
      if (n > 20000) begin
        n_mismatch++;
        report_and_stop();
      end
    end
  endtask
  // the clear pulse may land on any of the next few edges
  task automatic cfg_set(input logic [7:0] d);
    p = 1'b0;
    i_tss_host_model.cfg_write(d);
    repeat (3) begin
      #1;
      p = p | key_fifo_clr_ff;
      @(posedge clk);
    end
    #1;
  endtask
  task automatic fire(input logic a, input tss_cmd_t c);
    @(posedge clk);
    alert_evt <= a;
    key_evt   <= ~a;
    alert_cmd <= c;
    key_cmd   <= c;
    @(posedge clk);
    alert_evt <= 1'b0;
    key_evt   <= 1'b0;
    tick(3);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    sys_rst = 1'b1;
    {alert_evt, key_evt, alert_in, alert_irq_en} = 4'h0;
    {int_gpo_en, int_gpo_val} = 2'h0;
    {alert_cmd, key_cmd, sco_en, sco_val} = 28'h0;
    key_sense = 64'h0;
    n_mismatch = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    tick(1);
    check({snd_rd_data_ff, sounder_out_ff, run_mode_ff}, 10'h000);
    wr(8'h92, 2'b10);
    tick(2);
    check({snd_rd_data_ff, sounder_out_ff}, 9'h000);
    cfg_set(8'h80);
    check({p, run_mode_ff}, 2'b11);
    $display("test wake done");
    for (int d = 1; d < 8; d++) begin
      wr({d[2:0], 4'hc, 1'b0}, 2'b10);
      tick(1);
      check(snd_rd_data_ff, {d[2:0], 4'hc, 1'b0});
      wait_on(1'b0, 1'b0);
      h = BASE << (d - 1);
      check(n >= h - 2 && n <= h + 2 * half(1) + 4, 1'b1);
      check(sounder_out_ff, 1'b0);
    end
    $display("test durations done");
    for (int i = 0; i < 5; i++) begin
      wr({3'h0, tone_code[i], 1'b0}, 2'b10);
      wait_on(1'b1, 1'b0);
      wait_on(1'b1, 1'b1);
      n = 0;
      while (sounder_out_ff === 1'b1 && n < 400) begin
        tick(1);
        n++;
      end
      check(n >= half(i) - 1 && n <= half(i) + 1, 1'b1);
    end
    wr(8'h00, 2'b10);
    tick(2);
    check({snd_rd_data_ff, sounder_out_ff}, 9'h000);
    $display("test tones done");
    fire(1'b0, 8'h1b);
    check(snd_rd_data_ff[4:0], 5'h1a);
    wait_on(1'b0, 1'b0);
    h = BASE << 6;
    check(n >= h - 4 && n <= h + 2 * half(2) + 4, 1'b1);
    wr(8'h92, 2'b10);
    wr(8'h95, 2'b10);
    tick(1);
    check(snd_rd_data_ff, 8'h93);
    fire(1'b1, 8'hf8);
    check(snd_rd_data_ff[4:0], 5'h18);
    wr(8'h92, 2'b01);
    fire(1'b0, 8'h1b);
    check(snd_rd_data_ff[0], 1'b1);
    fire(1'b0, 8'h1f);
    check(snd_rd_data_ff, 8'hf9);
    wait_on(1'b0, 1'b0);
    $display("test events done");
    wr(8'h02, 2'b10);
    wr(8'h95, 2'b10);
    key_sense <= 64'h0000_0000_0004_0000;
    sco_en <= 6'h01;
    cfg_set(8'h00);
    check({p, run_mode_ff, sounder_out_ff, snd_rd_data_ff[0]}, 4'h2);
    check({row_oe, col_oe}, 16'h0004);
    check({row_o, col_o}, 16'h0000);
    check(key_state_ff, 64'h0);
    wr(8'h00, 2'b10);
    fire(1'b0, 8'h9b);
    check({sounder_out_ff, snd_rd_data_ff[0]}, 2'b10);
    int_gpo_en <= 1'b1;
    int_gpo_val <= 1'b1;
    sco_val <= 6'h01;
    tick(3);
    check({irq_oe_ff, col_oe}, 9'h000);
    int_gpo_val <= 1'b0;
    tick(3);
    check(irq_oe_ff, 1'b1);
    {int_gpo_en, alert_irq_en, alert_in} <= 3'b011;
    tick(3);
    check({alert_status_ff, irq_oe_ff}, 2'b11);
    key_sense <= 64'h0;
    cfg_set(8'h80);
    check({p, sounder_out_ff, snd_rd_data_ff}, 10'h200);
    wr(8'h92, 2'b10);
    wr(8'h95, 2'b10);
    cfg_set(8'h80);
    check({p, snd_rd_data_ff}, 9'h093);
    $display("test shutdown done");
    key_sense <= 64'h0000_0000_0000_0103;
    tick(30);
    check(key_state_ff, 64'h0);
    key_sense <= 64'h0000_0000_0004_0000;
    tick(2);
    check(key_state_ff, 64'h0);
    tick(30);
    check(key_state_ff, 64'h0000_0000_0004_0000);
    key_sense <= 64'h0;
    tick(2);
    check(key_state_ff, 64'h0);
    $display("test keys done");
    report_and_stop();
  end
endmodule
